// File: shared/agps_defines.svh
// constants of the ascii gateway protocol engine
`ifndef AGPS_DEFINES_SVH
`define AGPS_DEFINES_SVH
`define AGPS_ERR_QUEUE_OVR      8'h10
`define AGPS_ERR_DATA_OVR       8'h11
`define AGPS_ERR_STAT_SET       8'h12
`define AGPS_ERR_STAT_CLR       8'h13
`define AGPS_ERR_BUS_OFF        8'h14
`define AGPS_BAD_FRAME_FORMAT   8'h20
`define AGPS_BAD_REMOTE_FLAG    8'h21
`define AGPS_ERR_CONN_REJECT    8'h70
`define AGPS_IDENT_ABSENT       8'h75
`define AGPS_IDENT_DUPLICATE    8'h76
`define AGPS_ERR_LIST_FULL      8'h77
`define AGPS_ERR_CMD_UNKNOWN    8'h80
`define AGPS_ERR_BAUD_UNKNOWN   8'h81
`define AGPS_BITRATE_DETECT_FAIL 8'h82
`define AGPS_ERR_SET_BAUD       8'h83
`define AGPS_ERR_STATE_WRONG    8'h90
`define AGPS_PEND_W             7
`define AGPS_PEND_QUEUE         3'h0
`define AGPS_PEND_FMT           3'h5
`define AGPS_PEND_RTR           3'h6
`define AGPS_ERR_LINE_LEN       4'hb
`define AGPS_INFO_LINE_LEN      4'h6
`define AGPS_CH_E               8'h45
`define AGPS_CH_I               8'h49
`define AGPS_CH_SP              8'h20
`define AGPS_CH_CR              8'h0d
`define AGPS_CH_LF              8'h0a
`define AGPS_CH_O               8'h4f
`define AGPS_CH_K               8'h4b
`define AGPS_CH_F               8'h46
`define AGPS_CH_A               8'h41
`define AGPS_CH_L               8'h4c
`define AGPS_CH_0               8'h30
`define AGPS_CH_HEXA            8'h37
`endif

// File: shared/agps_pkg.sv
// types of the ascii gateway protocol engine
package agps_pkg;
	typedef enum logic [3:0] {
		AGPS_CMD_INIT, AGPS_CMD_INIT_AUTO, AGPS_CMD_START, AGPS_CMD_STOP, AGPS_CMD_RESET,
		AGPS_CMD_F_ADD, AGPS_CMD_F_REMOVE, AGPS_CMD_F_SEARCH, AGPS_CMD_F_CLEAR,
		AGPS_CMD_F_ENABLE, AGPS_CMD_F_DISABLE, AGPS_CMD_F_LOAD, AGPS_CMD_F_SAVE,
		AGPS_CMD_UNKNOWN
	} agps_cmd_e;
	typedef enum logic [2:0] {
		AGPS_CTL_INIT, AGPS_CTL_AUTO, AGPS_CTL_START, AGPS_CTL_STOP, AGPS_CTL_RESET
	} agps_ctl_e;
	typedef enum logic [2:0] {
		AGPS_FOP_NOP, AGPS_FOP_ADD, AGPS_FOP_REMOVE, AGPS_FOP_CLEAR, AGPS_FOP_WRITE
	} agps_fop_e;
	typedef enum logic [3:0] {
		AGPS_ST_IDLE = 4'h1, AGPS_ST_LOAD = 4'h2, AGPS_ST_CTRL = 4'h4, AGPS_ST_SAVE = 4'h8
	} agps_state_e;
	typedef struct packed {
		agps_cmd_e   op;
		logic [15:0] baud;
		logic [10:0] ident;
	} agps_cmd_s;
	typedef struct packed {
		logic        fmtBad;
		logic        rtrBad;
		logic [10:0] ident;
		logic [3:0]  len;
		logic [63:0] data;
	} agps_frame_s;
	typedef struct packed {
		logic dataOverrun;
		logic statusSet;
		logic statusCleared;
		logic busOff;
	} agps_fault_s;
endpackage : agps_pkg

// File: src/agps_filter_list.sv
// working ram copy of the identifier filter list
`timescale 1ns/1ps
module agps_filter_list #(
	parameter int DEPTH = 16,
	parameter int IDW   = 11,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic                mclk,
	input  wire logic                rst,
	input  agps_pkg::agps_fop_e      op,
	input  wire logic [IDW-1:0]      opIdent,
	input  wire logic [AW-1:0]       wrIdx,
	input  wire logic [IDW:0]        wrEntry,
	input  wire logic [AW-1:0]       rdIdx,
	output logic      [IDW:0]        rdEntry,
	output logic                     hit,
	output logic                     full,
	input  wire logic [IDW-1:0]      matchIdent,
	output logic                     match
);
	logic [IDW:0]   mem_q [DEPTH];
	logic [IDW:0]   mem_d [DEPTH];
	logic [AW-1:0]  hitIdx;
	logic [AW-1:0]  freeIdx;

	always_comb
	begin
		hit = 1'b0;
		full = 1'b1;
		match = 1'b0;
		hitIdx = '0;
		freeIdx = '0;
		for (int i = DEPTH - 1; i >= 0; i--)
		begin
			if (mem_q[i][IDW] && mem_q[i][IDW-1:0] == opIdent)
			begin
				hit = 1'b1;
				hitIdx = AW'(i);
			end
			if (!mem_q[i][IDW])
			begin
				full = 1'b0;
				freeIdx = AW'(i);
			end
			if (mem_q[i][IDW] && mem_q[i][IDW-1:0] == matchIdent)
				match = 1'b1;
		end
		rdEntry = mem_q[rdIdx];
		mem_d = mem_q;
		case (op)
			agps_pkg::AGPS_FOP_ADD:
				if (!hit && !full)
					mem_d[freeIdx] = {1'b1, opIdent};
			agps_pkg::AGPS_FOP_REMOVE:
				if (hit)
					mem_d[hitIdx] = '0;
			agps_pkg::AGPS_FOP_CLEAR:
				for (int i = 0; i < DEPTH; i++)
					mem_d[i] = '0;
			agps_pkg::AGPS_FOP_WRITE:
				mem_d[wrIdx] = wrEntry;
			default:
				mem_d = mem_q;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		else
			mem_q <= mem_d;
	end
endmodule : agps_filter_list

// File: src/agps_protocol_server.sv
// protocol engine: commands, replies, filtering and frame forwarding
`timescale 1ns/1ps
`include "agps_defines.svh"
module agps_protocol_server #(
	parameter int DEPTH = 16,
	parameter int IDW   = 11,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  cmdValid,
	input  agps_pkg::agps_cmd_s        cmdIn,
	output logic                       cmdReady,
	input  wire logic                  canRxValid,
	input  agps_pkg::agps_frame_s      canRx,
	output logic                       toNetValid,
	output agps_pkg::agps_frame_s      toNet,
	input  wire logic                  toNetReady,
	input  wire logic                  netRxValid,
	input  agps_pkg::agps_frame_s      netRx,
	output logic                       toCanValid,
	output agps_pkg::agps_frame_s      toCan,
	input  wire logic                  toCanReady,
	input  agps_pkg::agps_fault_s      canFault,
	output logic                       ctrlReq,
	output agps_pkg::agps_ctl_e        ctrlOp,
	output logic [15:0]                ctrlBaud,
	input  wire logic                  ctrlDone,
	input  wire logic                  ctrlFail,
	output logic                       flashReq,
	output logic                       flashWe,
	output logic [AW-1:0]              flashAddr,
	output logic [IDW:0]               flashWdata,
	input  wire logic [IDW:0]          flashRdata,
	input  wire logic                  flashAck,
	output logic                       replyValid,
	output logic [7:0]                 replyByte,
	input  wire logic                  replyReady,
	input  wire logic                  connAttempt,
	input  wire logic                  sessionActive,
	output logic                       connReject,
	output logic                       filterOn,
	output logic                       canStarted
);
	function automatic logic baudKnown(input logic [15:0] b);
		case (b)
			16'h0000, 16'h000a, 16'h0014, 16'h0032, 16'h0064, 16'h007d, 16'h00fa, 16'h01f4, 16'h03e8:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : baudKnown

	function automatic logic [7:0] hexChar(input logic [3:0] n);
		return (n < 4'ha) ? (`AGPS_CH_0 + {4'h0, n}) : (`AGPS_CH_HEXA + {4'h0, n});
	endfunction : hexChar

	function automatic logic [7:0] lineChar(input logic isErr, input logic [7:0] code, input logic [3:0] i);
		logic [7:0] c;
		c = `AGPS_CH_LF;
		if (isErr)
			case (i)
				4'h0: c = `AGPS_CH_E;
				4'h1, 4'h4: c = `AGPS_CH_SP;
				4'h2: c = hexChar(code[7:4]);
				4'h3: c = hexChar(code[3:0]);
				4'h5: c = `AGPS_CH_F;
				4'h6: c = `AGPS_CH_A;
				4'h7: c = `AGPS_CH_I;
				4'h8: c = `AGPS_CH_L;
				4'h9: c = `AGPS_CH_CR;
				default: c = `AGPS_CH_LF;
			endcase
		else
			case (i)
				4'h0: c = `AGPS_CH_I;
				4'h1: c = `AGPS_CH_SP;
				4'h2: c = `AGPS_CH_O;
				4'h3: c = `AGPS_CH_K;
				4'h4: c = `AGPS_CH_CR;
				default: c = `AGPS_CH_LF;
			endcase
		return c;
	endfunction : lineChar

	function automatic logic [7:0] pendCode(input logic [2:0] i);
		case (i)
			3'h0: return `AGPS_ERR_QUEUE_OVR;
			3'h1: return `AGPS_ERR_DATA_OVR;
			3'h2: return `AGPS_ERR_STAT_SET;
			3'h3: return `AGPS_ERR_STAT_CLR;
			3'h4: return `AGPS_ERR_BUS_OFF;
			3'h5: return `AGPS_BAD_FRAME_FORMAT;
			default: return `AGPS_BAD_REMOTE_FLAG;
		endcase
	endfunction : pendCode

	agps_pkg::agps_state_e    state_q, state_d;
	logic [AW-1:0]            idx_q, idx_d;
	logic                     fromCmd_q, fromCmd_d;
	logic                     inited_q, inited_d;
	logic                     started_q, started_d;
	logic                     filterOn_q, filterOn_d;
	agps_pkg::agps_ctl_e      ctrlOp_q, ctrlOp_d;
	logic                     ctrlReq_q, ctrlReq_d;
	logic [15:0]              ctrlBaud_q, ctrlBaud_d;
	logic                     flashReq_q, flashReq_d;
	logic                     flashWe_q, flashWe_d;
	logic [IDW:0]             flashWdata_q, flashWdata_d;
	logic                     respValid_q, respValid_d;
	logic                     respErr_q, respErr_d;
	logic [7:0]               respCode_q, respCode_d;
	logic [`AGPS_PEND_W-1:0]  pend_q, pend_d;
	logic                     lineOn_q, lineOn_d;
	logic                     lineErr_q, lineErr_d;
	logic [7:0]               lineCode_q, lineCode_d;
	logic [3:0]               pos_q, pos_d;
	logic [7:0]               replyByte_q, replyByte_d;
	agps_pkg::agps_frame_s    toNet_q, toNet_d;
	logic                     toNetValid_q, toNetValid_d;
	agps_pkg::agps_frame_s    toCan_q, toCan_d;
	logic                     toCanValid_q, toCanValid_d;
	logic                     connReject_q, connReject_d;
	agps_pkg::agps_fop_e      fop;
	logic [AW-1:0]            fWrIdx;
	logic [IDW:0]             rdEntry;
	logic                     fHit;
	logic                     fFull;
	logic                     fMatch;
	logic [`AGPS_PEND_W-1:0]  pendSet;
	logic [`AGPS_PEND_W-1:0]  pendClr;
	logic                     lastIdx;

	agps_filter_list #(.DEPTH(DEPTH), .IDW(IDW), .AW(AW)) u_list (
		.mclk       (mclk),
		.rst        (rst),
		.op         (fop),
		.opIdent    (cmdIn.ident),
		.wrIdx      (fWrIdx),
		.wrEntry    (flashRdata),
		.rdIdx      (idx_q),
		.rdEntry    (rdEntry),
		.hit        (fHit),
		.full       (fFull),
		.matchIdent (canRx.ident),
		.match      (fMatch)
	);

	assign lastIdx = (idx_q == AW'(DEPTH - 1));
	assign fWrIdx = idx_q;

	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		fromCmd_d = fromCmd_q;
		inited_d = inited_q;
		started_d = started_q;
		filterOn_d = filterOn_q;
		ctrlOp_d = ctrlOp_q;
		ctrlReq_d = 1'b0;
		ctrlBaud_d = ctrlBaud_q;
		flashReq_d = flashReq_q;
		flashWe_d = flashWe_q;
		flashWdata_d = flashWdata_q;
		respValid_d = respValid_q;
		respErr_d = respErr_q;
		respCode_d = respCode_q;
		cmdReady = 1'b0;
		fop = agps_pkg::AGPS_FOP_NOP;
		case (state_q)
			agps_pkg::AGPS_ST_IDLE:
			begin
				cmdReady = !respValid_q;
				if (cmdValid && cmdReady)
				begin
					respValid_d = 1'b1;
					respErr_d = 1'b0;
					respCode_d = '0;
					case (cmdIn.op)
						agps_pkg::AGPS_CMD_INIT, agps_pkg::AGPS_CMD_INIT_AUTO:
							if (started_q)
							begin
								respErr_d = 1'b1;
								respCode_d = `AGPS_ERR_STATE_WRONG;
							end
							else if (cmdIn.op == agps_pkg::AGPS_CMD_INIT && !baudKnown(cmdIn.baud))
							begin
								respErr_d = 1'b1;
								respCode_d = `AGPS_ERR_BAUD_UNKNOWN;
							end
							else
							begin
								respValid_d = 1'b0;
								ctrlReq_d = 1'b1;
								ctrlBaud_d = cmdIn.baud;
								ctrlOp_d = (cmdIn.op == agps_pkg::AGPS_CMD_INIT) ? agps_pkg::AGPS_CTL_INIT :
								           agps_pkg::AGPS_CTL_AUTO;
								state_d = agps_pkg::AGPS_ST_CTRL;
							end
						agps_pkg::AGPS_CMD_START, agps_pkg::AGPS_CMD_STOP, agps_pkg::AGPS_CMD_RESET:
							if (cmdIn.op == agps_pkg::AGPS_CMD_START && (!inited_q || started_q))
							begin
								respErr_d = 1'b1;
								respCode_d = `AGPS_ERR_STATE_WRONG;
							end
							else
							begin
								respValid_d = 1'b0;
								ctrlReq_d = 1'b1;
								ctrlOp_d = (cmdIn.op == agps_pkg::AGPS_CMD_START) ? agps_pkg::AGPS_CTL_START :
								           (cmdIn.op == agps_pkg::AGPS_CMD_STOP) ? agps_pkg::AGPS_CTL_STOP :
								           agps_pkg::AGPS_CTL_RESET;
								state_d = agps_pkg::AGPS_ST_CTRL;
							end
						agps_pkg::AGPS_CMD_F_ADD:
						begin
							fop = agps_pkg::AGPS_FOP_ADD;
							respErr_d = fHit || fFull;
							respCode_d = fHit ? `AGPS_IDENT_DUPLICATE : `AGPS_ERR_LIST_FULL;
						end
						agps_pkg::AGPS_CMD_F_REMOVE, agps_pkg::AGPS_CMD_F_SEARCH:
						begin
							fop = (cmdIn.op == agps_pkg::AGPS_CMD_F_REMOVE) ? agps_pkg::AGPS_FOP_REMOVE :
							      agps_pkg::AGPS_FOP_NOP;
							respErr_d = !fHit;
							respCode_d = `AGPS_IDENT_ABSENT;
						end
						agps_pkg::AGPS_CMD_F_CLEAR:
							fop = agps_pkg::AGPS_FOP_CLEAR;
						agps_pkg::AGPS_CMD_F_ENABLE, agps_pkg::AGPS_CMD_F_DISABLE:
							filterOn_d = (cmdIn.op == agps_pkg::AGPS_CMD_F_ENABLE);
						agps_pkg::AGPS_CMD_F_LOAD, agps_pkg::AGPS_CMD_F_SAVE:
						begin
							respValid_d = 1'b0;
							fromCmd_d = 1'b1;
							idx_d = '0;
							flashReq_d = 1'b1;
							flashWe_d = (cmdIn.op == agps_pkg::AGPS_CMD_F_SAVE);
							state_d = flashWe_d ? agps_pkg::AGPS_ST_SAVE : agps_pkg::AGPS_ST_LOAD;
						end
						default:
						begin
							respErr_d = 1'b1;
							respCode_d = `AGPS_ERR_CMD_UNKNOWN;
						end
					endcase
				end
			end
			agps_pkg::AGPS_ST_LOAD, agps_pkg::AGPS_ST_SAVE:
			begin
				flashWdata_d = rdEntry;
				if (flashAck)
				begin
					if (state_q == agps_pkg::AGPS_ST_LOAD)
						fop = agps_pkg::AGPS_FOP_WRITE;
					idx_d = idx_q + 1'b1;
					if (lastIdx)
					begin
						flashReq_d = 1'b0;
						flashWe_d = 1'b0;
						state_d = agps_pkg::AGPS_ST_IDLE;
						respValid_d = fromCmd_q;
						respErr_d = 1'b0;
					end
				end
			end
			agps_pkg::AGPS_ST_CTRL:
				if (ctrlDone)
				begin
					state_d = agps_pkg::AGPS_ST_IDLE;
					respValid_d = 1'b1;
					respErr_d = ctrlFail;
					respCode_d = (ctrlOp_q == agps_pkg::AGPS_CTL_AUTO) ? `AGPS_BITRATE_DETECT_FAIL :
					             `AGPS_ERR_SET_BAUD;
					if (!ctrlFail)
						case (ctrlOp_q)
							agps_pkg::AGPS_CTL_INIT, agps_pkg::AGPS_CTL_AUTO: inited_d = 1'b1;
							agps_pkg::AGPS_CTL_START: started_d = 1'b1;
							default:
							begin
								started_d = 1'b0;
								inited_d = (ctrlOp_q == agps_pkg::AGPS_CTL_STOP) && inited_q;
							end
						endcase
				end
			default:
				state_d = agps_pkg::AGPS_ST_IDLE;
		endcase
		if (!lineOn_q && respValid_q)
			respValid_d = 1'b0;
	end

	// frame paths: one holding register per direction keeps arrival order
	always_comb
	begin
		pendSet = '0;
		toNet_d = toNet_q;
		toNetValid_d = toNetValid_q && !toNetReady;
		toCan_d = toCan_q;
		toCanValid_d = toCanValid_q && !toCanReady;
		if (canRxValid && started_q && (!filterOn_q || fMatch))
		begin
			if (toNetValid_d)
				pendSet[`AGPS_PEND_QUEUE] = 1'b1;
			else
			begin
				toNet_d = canRx;
				toNetValid_d = 1'b1;
			end
		end
		if (netRxValid && started_q)
		begin
			if (netRx.fmtBad)
				pendSet[`AGPS_PEND_FMT] = 1'b1;
			else if (netRx.rtrBad)
				pendSet[`AGPS_PEND_RTR] = 1'b1;
			else if (toCanValid_d)
				pendSet[`AGPS_PEND_QUEUE] = 1'b1;
			else
			begin
				toCan_d = netRx;
				toCanValid_d = 1'b1;
			end
		end
		pendSet[4:1] = {canFault.busOff, canFault.statusCleared,
		                canFault.statusSet, canFault.dataOverrun};
		connReject_d = connAttempt && sessionActive;
	end

	// reply serializer: a command answer wins over queued fault lines
	always_comb
	begin
		lineOn_d = lineOn_q;
		lineErr_d = lineErr_q;
		lineCode_d = lineCode_q;
		pos_d = pos_q;
		pendClr = '0;
		if (!lineOn_q)
		begin
			pos_d = '0;
			if (respValid_q)
			begin
				lineOn_d = 1'b1;
				lineErr_d = respErr_q;
				lineCode_d = respCode_q;
			end
			else
				for (int i = `AGPS_PEND_W - 1; i >= 0; i--)
					if (pend_q[i])
					begin
						lineOn_d = 1'b1;
						lineErr_d = 1'b1;
						lineCode_d = pendCode(3'(i));
						pendClr = '0;
						pendClr[i] = 1'b1;
					end
		end
		else if (replyReady)
		begin
			pos_d = pos_q + 1'b1;
			if (pos_q == (lineErr_q ? `AGPS_ERR_LINE_LEN : `AGPS_INFO_LINE_LEN) - 4'h1)
				lineOn_d = 1'b0;
		end
		replyByte_d = lineChar(lineErr_d, lineCode_d, pos_d);
		pend_d = (pend_q & ~pendClr) | pendSet;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= agps_pkg::AGPS_ST_LOAD;
			idx_q <= '0;
			fromCmd_q <= 1'b0;
			inited_q <= 1'b0;
			started_q <= 1'b0;
			filterOn_q <= 1'b0;
			ctrlOp_q <= agps_pkg::AGPS_CTL_INIT;
			ctrlReq_q <= 1'b0;
			ctrlBaud_q <= '0;
			flashReq_q <= 1'b1;
			flashWe_q <= 1'b0;
			flashWdata_q <= '0;
			respValid_q <= 1'b0;
			respErr_q <= 1'b0;
			respCode_q <= '0;
			pend_q <= '0;
			lineOn_q <= 1'b0;
			lineErr_q <= 1'b0;
			lineCode_q <= '0;
			pos_q <= '0;
			replyByte_q <= '0;
			toNet_q <= '0;
			toNetValid_q <= 1'b0;
			toCan_q <= '0;
			toCanValid_q <= 1'b0;
			connReject_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
			fromCmd_q <= fromCmd_d;
			inited_q <= inited_d;
			started_q <= started_d;
			filterOn_q <= filterOn_d;
			ctrlOp_q <= ctrlOp_d;
			ctrlReq_q <= ctrlReq_d;
			ctrlBaud_q <= ctrlBaud_d;
			flashReq_q <= flashReq_d;
			flashWe_q <= flashWe_d;
			flashWdata_q <= flashWdata_d;
			respValid_q <= respValid_d;
			respErr_q <= respErr_d;
			respCode_q <= respCode_d;
			pend_q <= pend_d;
			lineOn_q <= lineOn_d;
			lineErr_q <= lineErr_d;
			lineCode_q <= lineCode_d;
			pos_q <= pos_d;
			replyByte_q <= replyByte_d;
			toNet_q <= toNet_d;
			toNetValid_q <= toNetValid_d;
			toCan_q <= toCan_d;
			toCanValid_q <= toCanValid_d;
			connReject_q <= connReject_d;
		end
	end

	// flash address follows the entry index; write data lags one cycle behind
	logic [AW-1:0] flashAddr_q;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			flashAddr_q <= '0;
		else
			flashAddr_q <= idx_d;
	end

	assign toNetValid = toNetValid_q;
	assign toNet = toNet_q;
	assign toCanValid = toCanValid_q;
	assign toCan = toCan_q;
	assign ctrlReq = ctrlReq_q;
	assign ctrlOp = ctrlOp_q;
	assign ctrlBaud = ctrlBaud_q;
	assign flashReq = flashReq_q;
	assign flashWe = flashWe_q;
	assign flashAddr = flashAddr_q;
	assign flashWdata = flashWdata_q;
	assign replyValid = lineOn_q;
	assign replyByte = replyByte_q;
	assign connReject = connReject_q;
	assign filterOn = filterOn_q;
	assign canStarted = started_q;
endmodule : agps_protocol_server

// File: verif/agps_protocol_checker.sv
// port assertions of the protocol engine
`timescale 1ns/1ps
module agps_protocol_checker (
	input wire logic		mclk,
	input wire logic		rst,
	input wire logic		cmdValid,
	input agps_pkg::agps_cmd_s	cmdIn,
	input wire logic		cmdReady,
	input wire logic		canRxValid,
	input agps_pkg::agps_frame_s	canRx,
	input wire logic		toNetValid,
	input agps_pkg::agps_frame_s	toNet,
	input wire logic		netRxValid,
	input agps_pkg::agps_frame_s	netRx,
	input wire logic		toCanValid,
	input agps_pkg::agps_frame_s	toCan,
	input wire logic		ctrlReq,
	input wire logic		ctrlDone,
	input wire logic		flashAck,
	input wire logic		replyValid,
	input wire logic [7:0]		replyByte,
	input wire logic		replyReady,
	input wire logic		connAttempt,
	input wire logic		sessionActive,
	input wire logic		connReject,
	input wire logic		filterOn,
	input wire logic		canStarted
);
	logic		took;
	logic [10:0]	rxId;
	logic [10:0]	txId;
	assign took = cmdValid && cmdReady;
	assign rxId = canRx.ident;
	assign txId = netRx.ident;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	filter_answer_a: assert property (took && cmdIn.op inside
		{[agps_pkg::AGPS_CMD_F_ADD:agps_pkg::AGPS_CMD_F_DISABLE], agps_pkg::AGPS_CMD_UNKNOWN}
		|-> ##2 $rose(replyValid)) else $error("late answer");
	ctrl_cause_a: assert property (ctrlReq |-> $past(took)) else $error("stray request");
	idle_silent_a: assert property (!canStarted && !toNetValid |=> !toNetValid)
		else $error("frame before start");
	filter_off_a: assert property (canStarted && !filterOn && canRxValid && !toNetValid
		|=> toNetValid && toNet.ident == $past(rxId)) else $error("frame not forwarded");
	net_nofilter_a: assert property (canStarted && netRxValid && !netRx.fmtBad && !netRx.rtrBad
		&& !toCanValid |=> toCanValid && toCan.ident == $past(txId)) else $error("bus frame lost");
	reply_hold_a: assert property (replyValid && !replyReady |=> replyValid && $stable(replyByte))
		else $error("byte moved");
	info_cause_a: assert property ($rose(replyValid) && replyByte == 8'h49
		|-> $past(took, 2) || $past(ctrlDone, 2) || $past(flashAck, 2)) else $error("unasked info");
	conn_reject_a: assert property (connAttempt && sessionActive |=> connReject)
		else $error("no reject");
	reject_cause_a: assert property (connReject |-> $past(connAttempt) && $past(sessionActive))
		else $error("stray reject");
endmodule : agps_protocol_checker
bind agps_protocol_server agps_protocol_checker u_chk (.*);

// File: verif/agps_svc_model.sv
// flash and can controller responder
`timescale 1ns/1ps
module agps_svc_model #(
	parameter int DEPTH = 4,
	parameter int AW    = $clog2(DEPTH)
) (
	input wire logic		mclk,
	input wire logic		flashReq,
	input wire logic		flashWe,
	input wire logic [AW-1:0]	flashAddr,
	input wire logic [11:0]		flashWdata,
	output logic [11:0]		flashRdata,
	output logic			flashAck,
	input wire logic		ctrlReq,
	output logic			ctrlDone
);
	logic [11:0]	mem [DEPTH];
	int		cnt;
	int		dly;
	bit		slow;
	initial
	begin
		foreach (mem[i])
			mem[i] = 12'h000;
		mem[0] = 12'h923;
		flashAck = 1'b0;
		ctrlDone = 1'b0;
	end
	// read data is inverted except while flashAck is high, so a stale word cannot pass
	assign flashRdata = flashAck ? mem[flashAddr] : ~mem[flashAddr];
	// never acks in the first cycle of an address; control answers alternate fast and slow
	always @(posedge mclk)
	begin
		cnt <= flashReq && !flashAck ? cnt + 1 : 0;
		flashAck <= flashReq && cnt == 2;
		if (flashAck && flashWe)
			mem[flashAddr] <= flashWdata;
		ctrlDone <= dly == 1;
		dly <= ctrlReq ? (slow ? 20 : 1) : dly - (dly > 0);
		slow <= slow ^ ctrlReq;
	end
endmodule : agps_svc_model

// File: verif/tb.sv
// self-checking bench of the protocol engine
`timescale 1ns/1ps
module tb;
	localparam int DEPTH = 4;
	localparam string OK = "I OK\015\012";
	logic	mclk, rst, cmdValid, cmdReady, canRxValid, toNetValid, toNetReady, netRxValid, toCanValid;
	logic	toCanReady, ctrlReq, ctrlDone, ctrlFail, flashReq, flashWe, flashAck, replyValid, replyReady;
	logic	connAttempt, sessionActive, connReject, filterOn, canStarted;
	logic [1:0]	flashAddr;
	logic [11:0]	flashWdata, flashRdata;
	logic [15:0]	ctrlBaud;
	logic [7:0]	replyByte;
	agps_pkg::agps_cmd_s	cmdIn;
	agps_pkg::agps_frame_s	canRx, toNet, netRx, toCan;
	agps_pkg::agps_fault_s	canFault;
	agps_pkg::agps_ctl_e	ctrlOp;
	int	miscompares, samples_checked, cyc, hits;
	integer	seed;
	string	lineQ[$], cur;
	logic [74:0]	netQ[$], canQ[$];
	agps_protocol_server #(.DEPTH(DEPTH)) u_agps_protocol_server (.*);
	agps_svc_model #(.DEPTH(DEPTH)) u_agps_svc_model (.*);
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic string err(logic [7:0] c);
		return $sformatf("E %02X FAIL\015\012", c);
	endfunction : err
	task automatic close_out();
		cmp(lineQ.size() + netQ.size() + canQ.size() == 0, "expected result never seen");
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic cmp(logic ok, string m);
		samples_checked++;
		if (!ok)
		begin
			miscompares++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : cmp
	task automatic drain();
		for (int n = 0; n < 3000 && (lineQ.size() > 0 || replyValid !== 1'b0); n++)
		begin
			@(posedge mclk);
			#1;
		end
	endtask : drain
	task automatic cmd(agps_pkg::agps_cmd_e op, int baud, logic [10:0] id, string ln);
		drain();
		for (int n = 0; n < 3000 && cmdReady !== 1'b1; n++)
		begin
			@(posedge mclk);
			#1;
		end
		lineQ.push_back(ln);
		cmdIn = '{op, baud[15:0], id};
		cmdValid = 1'b1;
		@(posedge mclk);
		#1;
		cmdValid = 1'b0;
		drain();
	endtask : cmd
	task automatic frame(bit net, logic [10:0] id, bit fmt, bit rtr, bit fwd, string ln);
		agps_pkg::agps_frame_s f;
		f = '{fmt, rtr, id, 4'h8, {$random(seed), $random(seed)}};
		if (fwd && net)
			canQ.push_back({id, f.data});
		if (fwd && !net)
			netQ.push_back({id, f.data});
		if (ln != "")
			lineQ.push_back(ln);
		canRx = f;
		netRx = f;
		canRxValid = !net;
		netRxValid = net;
		@(posedge mclk);
		#1;
		{canRxValid, netRxValid} = 2'b00;
		canRx = ~f;
		netRx = ~f;
		drain();
	endtask : frame
	always @(posedge mclk)
		replyReady <= #1 ($random(seed) & 3) != 0;
	always @(posedge mclk)
	begin
		if (replyValid === 1'b1 && replyReady === 1'b1)
		begin
			cur = $sformatf("%s%c", cur, replyByte);
			if (replyByte === 8'h0a)
			begin
				cmp(lineQ.size() > 0 && cur == lineQ.pop_front(), "reply line");
				cur = "";
			end
		end
		if (toNetValid === 1'b1 && toNetReady === 1'b1)
			cmp(netQ.size() > 0 && netQ.pop_front() === {toNet.ident, toNet.data}, "to net");
		if (toCanValid === 1'b1 && toCanReady === 1'b1)
			cmp(canQ.size() > 0 && canQ.pop_front() === {toCan.ident, toCan.data}, "to bus");
		if (++cyc == 20000)
		begin
			miscompares++;
			close_out();
		end
	end
	initial
	begin
		seed = 32'haddaa6b3;
		{cmdValid, canRxValid, netRxValid, ctrlFail, connAttempt, sessionActive} = '0;
		{toNetReady, toCanReady, rst} = 3'h7;
		{cmdIn, canRx, netRx, canFault} = '0;
		repeat (12) @(posedge mclk);
		#1;
		rst = 1'b0;
		frame(0, 11'h123, 0, 0, 0, "");
		cmd(agps_pkg::AGPS_CMD_START, 0, 0, err(8'h90));
		cmd(agps_pkg::AGPS_CMD_INIT, 300, 0, err(8'h81));
		ctrlFail = 1'b1;
		cmd(agps_pkg::AGPS_CMD_INIT_AUTO, 0, 0, err(8'h82));
		cmd(agps_pkg::AGPS_CMD_INIT, 250, 0, err(8'h83));
		ctrlFail = 1'b0;
		cmd(agps_pkg::AGPS_CMD_INIT, 500, 0, OK);
		cmp(ctrlOp === agps_pkg::AGPS_CTL_INIT && ctrlBaud === 16'h01f4, "ctrl request");
		cmd(agps_pkg::AGPS_CMD_START, 0, 0, OK);
		cmd(agps_pkg::AGPS_CMD_INIT, 500, 0, err(8'h90));
		cmd(agps_pkg::AGPS_CMD_F_SEARCH, 0, 11'h123, OK);
		cmd(agps_pkg::AGPS_CMD_F_ADD, 0, 11'h123, err(8'h76));
		cmd(agps_pkg::AGPS_CMD_F_REMOVE, 0, 11'h055, err(8'h75));
		cmd(agps_pkg::AGPS_CMD_UNKNOWN, 0, 0, err(8'h80));
		frame(0, 11'h055, 0, 0, 1, "");
		cmd(agps_pkg::AGPS_CMD_F_ENABLE, 0, 0, OK);
		frame(0, 11'h055, 0, 0, 0, "");
		frame(1, 11'($random(seed)), 0, 0, 1, "");
		frame(1, 11'h055, 1, 0, 0, err(8'h20));
		frame(1, 11'h055, 0, 1, 0, err(8'h21));
		for (int i = 0; i < 4; i++)
			cmd(agps_pkg::AGPS_CMD_F_ADD, 0, 11'h2a0 + 11'(i), i < 3 ? OK : err(8'h77));
		frame(0, 11'h2a0, 0, 0, 1, "");
		cmd(agps_pkg::AGPS_CMD_F_SAVE, 0, 0, OK);
		hits = 0;
		for (int i = 0; i < DEPTH; i++)
			hits += u_agps_svc_model.mem[i] === 12'haa2;
		cmp(hits == 1, "saved list");
		toNetReady = 1'b0;
		frame(0, 11'h123, 0, 0, 1, "");
		frame(0, 11'h123, 0, 0, 0, err(8'h10));
		toNetReady = 1'b1;
		for (int i = 8'h11; i <= 8'h14; i++)
			lineQ.push_back(err(8'(i)));
		canFault = '{1'b1, 1'b1, 1'b1, 1'b1};
		@(posedge mclk);
		#1;
		canFault = '0;
		drain();
		{connAttempt, sessionActive} = 2'b11;
		@(posedge mclk);
		#1;
		connAttempt = 1'b0;
		cmp(connReject === 1'b1, "no reject");
		sessionActive = 1'b0;
		cmd(agps_pkg::AGPS_CMD_STOP, 0, 0, OK);
		cmp(ctrlOp === agps_pkg::AGPS_CTL_STOP && canStarted === 1'b0, "stop request");
		frame(0, 11'h123, 0, 0, 0, "");
		cmd(agps_pkg::AGPS_CMD_F_CLEAR, 0, 0, OK);
		cmd(agps_pkg::AGPS_CMD_F_SEARCH, 0, 11'h123, err(8'h75));
		cmd(agps_pkg::AGPS_CMD_F_LOAD, 0, 0, OK);
		cmd(agps_pkg::AGPS_CMD_F_SEARCH, 0, 11'h2a2, OK);
		cmd(agps_pkg::AGPS_CMD_F_DISABLE, 0, 0, OK);
		cmp(filterOn === 1'b0, "filter state");
		cmd(agps_pkg::AGPS_CMD_RESET, 0, 0, OK);
		cmd(agps_pkg::AGPS_CMD_START, 0, 0, err(8'h90));
		// let a stray forward of the last frame reach the monitor
		repeat (3) @(posedge mclk);
		close_out();
	end
endmodule : tb
